// ===== pkg/cmc_pkg.sv
// package: register map, mode field positions and reset values for the counter mode control block
package cmc_pkg;
  localparam logic [31:0] ADDR_MODE   = 32'h0000_0000;
  localparam logic [31:0] ADDR_LOAD   = 32'h0000_0004;
  localparam logic [31:0] ADDR_HOLD   = 32'h0000_0008;
  localparam logic [31:0] ADDR_CMD    = 32'h0000_000c;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
  localparam logic [31:0] ADDR_COUNT  = 32'h0000_0014;
  localparam logic [15:0] MODE_RESET  = 16'h0800;
  localparam int OUT_LSB   = 0;
  localparam int DIR_BIT   = 3;
  localparam int BCD_BIT   = 4;
  localparam int REP_BIT   = 5;
  localparam int RLD_BIT   = 6;
  localparam int SPG_BIT   = 7;
  localparam int GATE_LSB  = 13;
  // output forms
  localparam logic [2:0] OUT_HIZ    = 3'h0;
  localparam logic [2:0] OUT_LOW    = 3'h0;
  localparam logic [2:0] OUT_TC_HI  = 3'h1;
  localparam logic [2:0] OUT_TOGGLE = 3'h2;
  localparam logic [2:0] OUT_TC_LO  = 3'h5;
  localparam logic [2:0] OUT_OFF    = 3'h4;
  // gating field
  localparam logic [2:0] GATE_NONE   = 3'h0;
  localparam logic [2:0] GATE_HIGH   = 3'h4;
  localparam logic [2:0] GATE_LOW    = 3'h5;
  localparam logic [2:0] GATE_EDGE_R = 3'h6;
  localparam logic [2:0] GATE_EDGE_F = 3'h7;
  // command register bits
  localparam int CMD_ARM    = 0;
  localparam int CMD_LOAD   = 1;
  localparam int CMD_DISARM = 2;
  localparam int CMD_STEP   = 3;
  localparam int CMD_SETOUT = 4;
  localparam int CMD_CLROUT = 5;
  localparam int CMD_SAVE   = 6;
  localparam int CMD_MRST   = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== logic/cmc_next.sv
// counter next-value and pre-terminal decode for binary or bcd, up or down
`timescale 1ns/100ps
module cmc_next (
  input  wire logic [15:0] value,
  input  wire logic        up,
  input  wire logic        bcd,
  output logic      [15:0] next_value,
  output logic             pre_tc
);
  import cmc_pkg::*;
  logic [4:0] carry;
  logic [15:0] bcd_res;
  assign carry[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dig
      wire [3:0] d = value[g*4 +: 4];
      wire       wrap_up = (d == 4'h9);
      wire       wrap_dn = (d == 4'h0);
      assign bcd_res[g*4 +: 4] = !carry[g] ? d :
                                 up ? (wrap_up ? 4'h0 : d + 4'h1) :
                                      (wrap_dn ? 4'h9 : d - 4'h1);
      assign carry[g+1] = carry[g] & (up ? wrap_up : wrap_dn);
    end
  endgenerate
  assign next_value = bcd ? bcd_res : (up ? value + 16'h0001 : value - 16'h0001);
  assign pre_tc = up ? (bcd ? (value == 16'h9999) : (value == 16'hffff))
                     : (value == 16'h0001);
endmodule

// ===== logic/cmc_top.sv
// counter mode control group: mode register, counter core, reload and output logic
// Notes on behaviour
// - reset and master reset give mode 0800
// - mode bits 0-2 pick output form
// - terminal count after 0001 down, 9999/ffff up
// - terminal count lasts one source period maximum unless the reload value is pre-terminal
// - every terminal count reloads from load or hold
// - toggle flips at end of each terminal count
// - minimum-delay one-shot toggles on second pulse
// - set/clear output commands force toggle level unless a tc-ending count in the same cycle flips it
// - pre-terminal commit not delayed by retrigger/load
// - load before tc enters tc; during ends it
// - tc edge always counted; disarm applies after
// - pre-terminal reload keeps tc, toggles each count
// - direction and decimal bits act independently
// - repeat bit; else disarm after first tc
// - reload source: load, gate-selected, or alternating
// - retrigger saves count to hold, next edge loads
// - load command after retrigger acts as source edge
// - with gating, special bit enables retriggering
// - without gating, special bit with reload bit 6 set: gate selects reload
// - active-going gate retriggers; qualified needs arm, plus gate level except in edge gating modes
// - gate low picks load, high picks hold
// - no gating counts whenever armed
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
module cmc_top (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        count_src,
  input  wire logic        gate_in,
  output logic             out_o,
  output logic             out_oe
);
  import cmc_pkg::*;

  logic [15:0] mode_r, load_r, hold_r, cnt_r;
  logic        armed_r, tc_r, tog_r, retrig_r, alt_r, tc_seen_r, src_q_r, gate_q_r;
  logic        out_r, oe_r;
  logic        awr_r, wr_r, bv_r, arr_r, rv_r;
  logic [31:0] awa_r, wd_r, rd_r;
  logic [3:0]  ws_r;
  logic [1:0]  br_r, rr_r;

  // ---------------- bus slave ----------------
  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire have_aw = awr_r | aw_hs;
  wire have_w  = wr_r | w_hs;
  wire [31:0] wa_eff = awr_r ? awa_r : s_axi_awaddr;
  wire [31:0] wd_eff = wr_r ? wd_r : s_axi_wdata;
  wire [3:0]  ws_eff = wr_r ? ws_r : s_axi_wstrb;
  wire do_wr   = have_aw & have_w & !bv_r;
  wire wmode   = do_wr & (wa_eff == ADDR_MODE);
  wire wload   = do_wr & (wa_eff == ADDR_LOAD);
  wire whold   = do_wr & (wa_eff == ADDR_HOLD);
  wire wcmd    = do_wr & (wa_eff == ADDR_CMD) & ws_eff[0];
  wire wmapped = (wa_eff == ADDR_MODE) | (wa_eff == ADDR_LOAD) | (wa_eff == ADDR_HOLD)
               | (wa_eff == ADDR_CMD);
  wire [7:0] cmd = wcmd ? wd_eff[7:0] : 8'h00;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awr_r <= 1'b0;
      wr_r  <= 1'b0;
      awa_r <= 32'h0000_0000;
      wd_r  <= 32'h0000_0000;
      ws_r  <= 4'h0;
      bv_r  <= 1'b0;
      br_r  <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awr_r <= 1'b1;
        awa_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wr_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        awr_r <= 1'b0;
        wr_r  <= 1'b0;
        bv_r  <= 1'b1;
        br_r  <= wmapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bv_r && s_axi_bready) begin
        bv_r <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awr_r & !bv_r;
  assign s_axi_wready  = !wr_r & !bv_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;

  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire [31:0] rsel =
    (s_axi_araddr == ADDR_MODE)   ? {16'h0000, mode_r} :
    (s_axi_araddr == ADDR_LOAD)   ? {16'h0000, load_r} :
    (s_axi_araddr == ADDR_HOLD)   ? {16'h0000, hold_r} :
    (s_axi_araddr == ADDR_STATUS) ? {28'h0000000, tog_r, retrig_r, tc_r, armed_r} :
    (s_axi_araddr == ADDR_COUNT)  ? {16'h0000, cnt_r} : 32'h0000_0000;
  wire rmapped = (s_axi_araddr == ADDR_MODE) | (s_axi_araddr == ADDR_LOAD)
               | (s_axi_araddr == ADDR_HOLD) | (s_axi_araddr == ADDR_STATUS)
               | (s_axi_araddr == ADDR_COUNT) | (s_axi_araddr == ADDR_CMD);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rv_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rr_r <= RESP_OKAY;
    end else if (ar_hs) begin
      rv_r <= 1'b1;
      rd_r <= rsel;
      rr_r <= rmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rv_r && s_axi_rready) begin
      rv_r <= 1'b0;
    end
  end
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;

  // ---------------- mode decode ----------------
  wire [2:0] outsel = mode_r[OUT_LSB +: 3];
  wire [2:0] gsel   = mode_r[GATE_LSB +: 3];
  wire gating   = (gsel != GATE_NONE);
  wire edge_g   = (gsel == GATE_EDGE_R) | (gsel == GATE_EDGE_F);
  wire gate_act = (gsel == GATE_LOW) | (gsel == GATE_EDGE_F) ? !gate_in : gate_in;
  wire retrig_en = gating & mode_r[SPG_BIT];
  wire gsel_rld  = !gating & mode_r[SPG_BIT] & mode_r[RLD_BIT];
  wire alt_rld   = mode_r[RLD_BIT] & !gsel_rld;

  // ---------------- counter core ----------------
  logic [15:0] nxt_val;
  logic        pre_tc;
  cmc_next u_next (
    .value      (cnt_r),
    .up         (mode_r[DIR_BIT]),
    .bcd        (mode_r[BCD_BIT]),
    .next_value (nxt_val),
    .pre_tc     (pre_tc)
  );

  wire src_edge  = count_src & !src_q_r;
  wire gate_rise = gate_act & !gate_q_r;
  wire gate_ok   = !gating | (edge_g ? 1'b1 : gate_act);
  wire qual_edge = src_edge & armed_r & gate_ok;
  wire mrst    = cmd[CMD_MRST];
  wire c_load  = cmd[CMD_LOAD];
  wire c_step  = cmd[CMD_STEP];
  wire c_arm   = cmd[CMD_ARM];
  wire c_dis   = cmd[CMD_DISARM];
  // step always acts as a count edge; load only in the retrigger window or near terminal count
  wire cmd_edge = c_step | (c_load & (retrig_r | pre_tc | tc_r));
  // tc consumes the next source edge regardless of arm or gate
  wire tc_edge  = tc_r & src_edge;
  wire adv      = qual_edge | tc_edge | cmd_edge;
  wire hit_tc   = adv & pre_tc;
  wire retrig_ev = retrig_en & gate_rise & armed_r & !pre_tc;
  wire use_hold = gsel_rld ? gate_in : (alt_rld ? !alt_r : 1'b0);
  wire [15:0] reload_val = use_hold ? hold_r : load_r;
  wire last_tc  = !mode_r[REP_BIT] & (!alt_rld | tc_seen_r);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r    <= MODE_RESET;
      load_r    <= 16'h0000;
      hold_r    <= 16'h0000;
      cnt_r     <= 16'h0000;
      armed_r   <= 1'b0;
      tc_r      <= 1'b0;
      tog_r     <= 1'b0;
      retrig_r  <= 1'b0;
      alt_r     <= 1'b0;
      tc_seen_r <= 1'b0;
      src_q_r   <= 1'b0;
      gate_q_r  <= 1'b0;
    end else begin
      src_q_r  <= count_src;
      gate_q_r <= gate_act;
      if (wmode) mode_r <= merge16(mode_r, wd_eff, ws_eff);
      if (wload) load_r <= merge16(load_r, wd_eff, ws_eff);
      if (whold) hold_r <= merge16(hold_r, wd_eff, ws_eff);
      if (cmd[CMD_SAVE]) hold_r <= cnt_r;
      if (c_arm) begin
        armed_r   <= 1'b1;
        alt_r     <= 1'b0;
        tc_seen_r <= 1'b0;
      end
      if (c_dis & !tc_r) armed_r <= 1'b0;
      if (cmd[CMD_CLROUT]) tog_r <= 1'b0;
      if (cmd[CMD_SETOUT]) tog_r <= 1'b1;
      if (retrig_ev) begin
        hold_r   <= cnt_r;
        retrig_r <= 1'b1;
      end
      if (hit_tc) begin
        cnt_r     <= reload_val;
        tc_r      <= 1'b1;
        alt_r     <= alt_rld ? !alt_r : alt_r;
        tc_seen_r <= 1'b1;
        retrig_r  <= 1'b0;
      end else if (adv & retrig_r & !tc_r) begin
        cnt_r    <= load_r;
        retrig_r <= 1'b0;
      end else if (adv) begin
        cnt_r <= tc_r ? nxt_val : nxt_val;
        if (tc_r) tc_r <= 1'b0;
      end else if (c_load & !tc_r) begin
        cnt_r <= reload_val;
      end
      if (adv & tc_r) begin
        tog_r <= !tog_r;
        if (last_tc & !hit_tc) armed_r <= 1'b0;
        if (c_dis) armed_r <= 1'b0;
      end else if (adv & tc_r & hit_tc) begin
        tog_r <= !tog_r;
      end
      if (mrst) begin
        mode_r  <= MODE_RESET;
        armed_r <= 1'b0;
        tc_r    <= 1'b0;
      end
    end
  end

  // ---------------- output pin ----------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_r <= 1'b0;
      oe_r  <= 1'b1;
    end else begin
      case (outsel)
        OUT_LOW:    begin out_r <= 1'b0;   oe_r <= 1'b1; end
        OUT_TC_HI:  begin out_r <= tc_r;   oe_r <= 1'b1; end
        OUT_TOGGLE: begin out_r <= tog_r;  oe_r <= 1'b1; end
        OUT_TC_LO:  begin out_r <= !tc_r;  oe_r <= 1'b1; end
        OUT_OFF:    begin out_r <= 1'b0;   oe_r <= 1'b0; end
        default:    begin out_r <= 1'b0;   oe_r <= 1'b0; end
      endcase
    end
  end
  assign out_o  = out_r;
  assign out_oe = oe_r;

  // ---------------- checks ----------------
  AST_TC_ENDS: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tc_r && src_edge |=> !tc_r || pre_tc) else $error("tc outlived a source edge");
  AST_TC_HIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    qual_edge && pre_tc && !mrst |=> tc_r) else $error("tc not entered");
  AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!arst_n)
    hit_tc && !mrst |=> cnt_r == $past(reload_val)) else $error("bad reload");
  AST_TOGGLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tc_r && src_edge && !cmd[CMD_SETOUT] && !cmd[CMD_CLROUT] |=> tog_r != $past(tog_r))
    else $error("toggle missed");
  AST_SETOUT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cmd[CMD_SETOUT] && !adv |=> tog_r) else $error("set output failed");
  AST_MRST: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mrst |=> mode_r == MODE_RESET && !armed_r) else $error("master reset failed");
  AST_SAVE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    retrig_ev && !hit_tc |=> retrig_r && hold_r == $past(cnt_r)) else $error("save");
  AST_NOGATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !gating && armed_r && src_edge && !pre_tc && !retrig_r && !tc_r && cmd == 8'h00
    |=> cnt_r == $past(nxt_val)) else $error("ungated count lost");
  COV_TC:     cover property (@(posedge sys_clk) disable iff (!arst_n) hit_tc);
  COV_RETRIG: cover property (@(posedge sys_clk) disable iff (!arst_n) retrig_ev);
  COV_WRITE:  cover property (@(posedge sys_clk) disable iff (!arst_n) wmode);
endmodule

// ===== tb/cmc_src_model.sv
// partner model: drives the count source and gate pins of the counter group
`timescale 1ns/100ps
module cmc_src_model (
  input  wire logic sys_clk,
  output logic      count_src,
  output logic      gate_in
);
  initial begin
    count_src = 1'b0;
    gate_in   = 1'b0;
  end
  // one count source period, gate level set alongside
  task pulse(input logic g);
    begin
      gate_in   <= g;
      count_src <= 1'b1;
      repeat (2) @(posedge sys_clk);
      count_src <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule

// ===== tb/tb.sv
// testbench: counter mode control group against a behavioural count model
`timescale 1ns/100ps
module tb;
  import cmc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rdv;
  logic [3:0]  wstrb  = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, count_src, gate_in, out_o, out_oe;
  logic [1:0]  bresp, rresp, rsp;
  int          n_fail = 0, samples_checked = 0, cyc = 0, seed = 32'h0b69;
  int          v, tc, armed, tgl, up, bcd, rep, ld, k, otc;
  int          xm = 0, gs = 0, hl = 0;

  cmc_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .count_src(count_src), .gate_in(gate_in),
    .out_o(out_o), .out_oe(out_oe));
  cmc_src_model src (.sys_clk(sys_clk), .count_src(count_src), .gate_in(gate_in));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // write: address and data together, each released once taken
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic pa, pw, pb;
    int   t;
    begin
      pa = 1; pw = 1; pb = 1; t = 0;
      @(posedge sys_clk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while ((pa || pw || pb) && t < 100) begin
        @(negedge sys_clk);
        if (pb && bvalid) begin pb = 0; rsp = bresp; end
        if (awready) pa = 0;
        if (wready) pw = 0;
        @(posedge sys_clk);
        if (!pa) awvalid <= 1'b0;
        if (!pw) wvalid <= 1'b0;
        if (!pb) bready <= 1'b0;
        t++;
      end
      if (t >= 100) n_fail++;
    end
  endtask

  task rd(input logic [31:0] a);
    logic pa, pb;
    int   t;
    begin
      pa = 1; pb = 1; t = 0;
      @(posedge sys_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while ((pa || pb) && t < 100) begin
        @(negedge sys_clk);
        if (pb && rvalid) begin pb = 0; rdv = rdata; rsp = rresp; end
        if (arready) pa = 0;
        @(posedge sys_clk);
        if (!pa) arvalid <= 1'b0;
        if (!pb) rready <= 1'b0;
        t++;
      end
      if (t >= 100) n_fail++;
    end
  endtask

  task cmd(input int b);
    wr(ADDR_CMD, 32'(1 << b));
  endtask

  function automatic int nxt(int x);
    int r, d, i, c;
    if (!bcd) return up ? (x + 1) & 'hffff : (x - 1) & 'hffff;
    r = 0; c = 1;
    for (i = 0; i < 4; i++) begin
      d = (x >> (4 * i)) & 15;
      if (c && up) begin d = d + 1; c = (d == 10); if (c) d = 0; end
      else if (c) begin c = (d == 0); d = c ? 9 : d - 1; end
      r = r | (d << (4 * i));
    end
    return r;
  endfunction

  function automatic bit pre(int x);
    return up ? (x == (bcd ? 'h9999 : 'hffff)) : (x == 1);
  endfunction

  // one source period, then model update and readback
  task step;
    src.pulse(1'($random(seed)));
    if (armed || tc) begin
      otc = tc;
      if (pre(v)) begin v = (gs && src.gate_in) ? hl : ld; tc = 1; end
      else begin v = nxt(v); tc = 0; end
      if (otc) begin tgl = 1 - tgl; if (!rep) armed = 0; end
    end
    rd(ADDR_COUNT);
    chk("count", v, rdv);
    rd(ADDR_STATUS);
    chk("status", 32'(tgl * 8 + tc * 2 + armed), rdv & 32'hf);
    chk("out_o", 32'(tgl), 32'(out_o));
  endtask

  task run(input int u, input int b, input int r, input int l, input int np);
    up = u; bcd = b; rep = r; ld = l;
    cmd(CMD_DISARM);
    wr(ADDR_MODE, 32'h0800 | (u << DIR_BIT) | (b << BCD_BIT) | (r << REP_BIT) | OUT_TOGGLE | xm);
    wr(ADDR_LOAD, 32'(l));
    cmd(CMD_LOAD);
    cmd(CMD_SETOUT);
    cmd(CMD_ARM);
    v = l; tc = 0; armed = 1; tgl = 1;
    chk("out_o", 1, 32'(out_o));
    for (k = 0; k < np; k++) step();
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk("out_oe", 1, 32'(out_oe));
    chk("out_o", 0, 32'(out_o));
    rd(ADDR_MODE);
    chk("mode", 32'h0800, rdv);
    run(0, 0, 1, 3, 7);
    run(1, 0, 1, 'hfffd, 7);
    run(1, 1, 1, 'h9997, 7);
    run(0, 1, 1, 3, 7);
    run(0, 0, 0, 3, 5);
    rd(ADDR_MODE);
    chk("mode", 32'h0802, rdv & 32'hffff);
    src.pulse(1'b0);
    xm = 'hc0; gs = 1; hl = 5;
    wr(ADDR_HOLD, 32'(hl));
    run(0, 0, 1, 2, 12);
    xm = 0; gs = 0;
    run(0, 0, 1, 1, 4);
    cmd(CMD_CLROUT);
    @(negedge sys_clk);
    chk("out_o", 0, 32'(out_o));
    rd(32'h20);
    chk("rresp", 32'(RESP_SLVERR), 32'(rsp));
    chk("rdata", 0, rdv);
    wr(32'h20, 32'h1234);
    chk("bresp", 32'(RESP_SLVERR), 32'(rsp));
    wr(ADDR_MODE, 32'(OUT_OFF));
    rd(ADDR_MODE);
    chk("out_oe", 0, 32'(out_oe));
    cmd(CMD_MRST);
    rd(ADDR_MODE);
    chk("mode", 32'h0800, rdv);
    chk("out_oe", 1, 32'(out_oe));
    wrap_up();
  end
endmodule
